/* src/cmpl_irq_ctrl.sv */
// Overview of operation
// - writing one to a low clear bit clears pending codes 0-31; zeros ignored
// - writing one to a high clear bit clears pending codes 32-63; zeros ignored
// - after a line pulses, it gives no new completion interrupt, except by evaluate, until every set pending bit is cleared
// - evaluate register exists in global window and in each shadow window
// - shadow evaluate pulses only for enabled pending bits inside that region's dma access enables
// - evaluate bit 0 write of one pulses interrupt if enabled pending remains
// - the pulse goes to the line of the region whose evaluate was written
// - qdma channel registers hold one bit per channel at its number
// - qdma registers reachable globally and via shadows gated by qdma enables
// - completion code n sets pending bit n, low or high register
// - pending bits stay set until software clears them
`timescale 1ns/1ps
`default_nettype none
module cmpl_irq_ctrl
  import cmpl_irq_pkg::*;
#(
  parameter int REGIONS = NUM_REGIONS
)
(
  input wire logic pclk, // controller clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic code_valid, // completion code strobe
  input wire logic [CODE_W-1:0] completion_code, // completion code number
  output logic [REGIONS:0] cmpl_irq, // region pulses, top bit is global
  output logic [QDMA_CHANNELS-1:0] qdma_enable, // qdma channel enable bits
  output logic irq // level interrupt
);
  localparam int RW = $clog2(REGIONS + 1);

  logic [31:0] pend_lo_q, pend_lo_d, pend_hi_q, pend_hi_d;
  logic [31:0] en_lo_q, en_lo_d, en_hi_q, en_hi_d;
  logic [QDMA_CHANNELS-1:0] qen_q, qen_d;
  // per-region dma and qdma access grants
  logic [31:0] grant_lo_q [REGIONS];
  logic [31:0] grant_lo_d [REGIONS];
  logic [31:0] grant_hi_q [REGIONS];
  logic [31:0] grant_hi_d [REGIONS];
  logic [QDMA_CHANNELS-1:0] qgrant_q [REGIONS];
  logic [QDMA_CHANNELS-1:0] qgrant_d [REGIONS];
  logic [REGIONS-1:0] acc_sel;
  logic [REGIONS:0] status_q, status_d, mask_q, mask_d;
  logic [REGIONS:0] evaluate_req, region_hit, irq_pulse;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d, irq_d;
  logic access, wr;
  logic win_hit;
  logic [RW-1:0] win_reg;
  logic [4:0] win_ofs;
  logic [31:0] mask_lo, mask_hi;
  logic [QDMA_CHANNELS-1:0] qmask;
  logic [31:0] set_lo, set_hi, clr_lo, clr_hi;
  logic [63:0] code_onehot;
  logic all_clear;

  assign access = psel && penable && pready;
  assign wr = access && pwrite;

  // window decode: global window or one of the shadow windows
  always_comb
  begin
    win_hit = 1'b0;
    // global window maps to the top line
    win_reg = RW'(REGIONS);
    win_ofs = paddr[4:0];
    if (paddr >= GLOBAL_BASE && paddr < GLOBAL_BASE + WINDOW_SIZE)
      win_hit = 1'b1;
    for (int r = 0; r < REGIONS; r++)
    begin
      if (paddr >= SHADOW_BASE + ADDR_W'(r) * SHADOW_STRIDE &&
          paddr < SHADOW_BASE + ADDR_W'(r) * SHADOW_STRIDE + WINDOW_SIZE)
      begin
        win_hit = 1'b1;
        win_reg = RW'(r);
      end
    end
  end

  // access-grant register block select, one per region
  always_comb
  begin
    acc_sel = '0;
    for (int r = 0; r < REGIONS; r++)
      acc_sel[r] = {4'h0, paddr[ADDR_W-1:4]} == (ACC_BASE + ADDR_W'(r) * ACC_STRIDE) >> 4;
  end

  // shadow accesses see only the bits granted to that region
  always_comb
  begin
    mask_lo = 32'hFFFF_FFFF;
    mask_hi = 32'hFFFF_FFFF;
    qmask = '1;
    for (int r = 0; r < REGIONS; r++)
    begin
      if (win_reg == RW'(r))
      begin
        mask_lo = grant_lo_q[r];
        mask_hi = grant_hi_q[r];
        qmask = qgrant_q[r];
      end
    end
  end

  always_comb
  begin
    code_onehot = 64'h0;
    if (code_valid)
      code_onehot[completion_code] = 1'b1;
    set_lo = code_onehot[31:0];
    set_hi = code_onehot[63:32];
    clr_lo = 32'h0;
    clr_hi = 32'h0;
    if (wr && win_hit && win_ofs == OFS_CLR_LO)
      clr_lo = pwdata & mask_lo;
    if (wr && win_hit && win_ofs == OFS_CLR_HI)
      clr_hi = pwdata & mask_hi;
    // set applied after clear, so a code racing its own clear survives
    pend_lo_d = (pend_lo_q & ~clr_lo) | set_lo;
    pend_hi_d = (pend_hi_q & ~clr_hi) | set_hi;
    // rearm only once both pending words are empty
    all_clear = (pend_lo_q == 32'h0) && (pend_hi_q == 32'h0);
  end

  // enables, qdma channel bits, evaluate requests, access enables
  always_comb
  begin
    en_lo_d = en_lo_q;
    en_hi_d = en_hi_q;
    qen_d = qen_q;
    evaluate_req = '0;
    for (int r = 0; r < REGIONS; r++)
    begin
      grant_lo_d[r] = grant_lo_q[r];
      grant_hi_d[r] = grant_hi_q[r];
      qgrant_d[r] = qgrant_q[r];
    end
    if (wr && win_hit)
    begin
      unique case (win_ofs)
        OFS_EN_LO: en_lo_d = (en_lo_q & ~mask_lo) | (pwdata & mask_lo);
        OFS_EN_HI: en_hi_d = (en_hi_q & ~mask_hi) | (pwdata & mask_hi);
        OFS_QDMA_EN: qen_d = (qen_q & ~qmask) | (pwdata[QDMA_CHANNELS-1:0] & qmask);
        // only the trigger bit counts, its neighbour is ignored
        OFS_EVALUATE: evaluate_req[win_reg] = pwdata[EVALUATE_TRIGGER_BIT];
        default: ;
      endcase
    end
    for (int r = 0; r < REGIONS; r++)
    begin
      if (wr && acc_sel[r])
      begin
        unique case (paddr[3:0])
          ACC_DMA_LO: grant_lo_d[r] = pwdata;
          ACC_DMA_HI: grant_hi_d[r] = pwdata;
          ACC_QDMA: qgrant_d[r] = pwdata[QDMA_CHANNELS-1:0];
          default: ;
        endcase
      end
    end
  end

  // per-region completion pulse generators, last one is the global line
  for (genvar g = 0; g <= REGIONS; g++)
  begin : gen_region
    logic [31:0] rm_lo, rm_hi;
    if (g < REGIONS)
    begin : gen_shadow
      assign rm_lo = grant_lo_q[g];
      assign rm_hi = grant_hi_q[g];
    end
    else
    begin : gen_global
      assign rm_lo = 32'hFFFF_FFFF;
      assign rm_hi = 32'hFFFF_FFFF;
    end
    assign region_hit[g] = |(pend_lo_q & en_lo_q & rm_lo) || |(pend_hi_q & en_hi_q & rm_hi);
    region_irq_gen u_gen
    (
      .pclk(pclk),
      .presetn(presetn),
      .enabled_pending(region_hit[g]),
      .all_clear(all_clear),
      .evaluate_req(evaluate_req[g]),
      .irq_q(irq_pulse[g])
    );
  end

  // sticky status, write one to clear, set wins
  always_comb
  begin
    status_d = status_q & ~((wr && paddr == IRQ_STATUS_ADDR) ? pwdata[REGIONS:0] : '0);
    status_d = status_d | irq_pulse;
    mask_d = (wr && paddr == IRQ_MASK_ADDR) ? pwdata[REGIONS:0] : mask_q;
    irq_d = |(status_d & mask_d);
  end

  // bus answer: one wait cycle, read data and error registered
  always_comb
  begin
    pready_d = psel && penable && !pready;
    prdata_d = 32'h0;
    pslverr_d = 1'b0;
    if (pready_d)
    begin
      pslverr_d = 1'b1;
      if (win_hit)
      begin
        pslverr_d = 1'b0;
        unique case (win_ofs)
          OFS_PEND_LO: prdata_d = pend_lo_q & mask_lo;
          OFS_PEND_HI: prdata_d = pend_hi_q & mask_hi;
          OFS_EN_LO: prdata_d = en_lo_q & mask_lo;
          OFS_EN_HI: prdata_d = en_hi_q & mask_hi;
          OFS_QDMA_EN: prdata_d = 32'(qen_q & qmask);
          // clear and evaluate words read as zero
          default: prdata_d = 32'h0;
        endcase
      end
      else if (paddr == IRQ_STATUS_ADDR)
      begin
        pslverr_d = 1'b0;
        prdata_d = 32'(status_q);
      end
      else if (paddr == IRQ_MASK_ADDR)
      begin
        pslverr_d = 1'b0;
        prdata_d = 32'(mask_q);
      end
      for (int r = 0; r < REGIONS; r++)
      begin
        if (acc_sel[r])
        begin
          pslverr_d = 1'b0;
          unique case (paddr[3:0])
            ACC_DMA_LO: prdata_d = grant_lo_q[r];
            ACC_DMA_HI: prdata_d = grant_hi_q[r];
            ACC_QDMA: prdata_d = 32'(qgrant_q[r]);
            default: pslverr_d = 1'b1;
          endcase
        end
      end
      if (pwrite)
        prdata_d = 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_lo_q <= RESET_WORD;
      pend_hi_q <= RESET_WORD;
      en_lo_q <= RESET_WORD;
      en_hi_q <= RESET_WORD;
      qen_q <= '0;
      for (int r = 0; r < REGIONS; r++)
      begin
        grant_lo_q[r] <= RESET_WORD;
        grant_hi_q[r] <= RESET_WORD;
        qgrant_q[r] <= '0;
      end
      status_q <= '0;
      mask_q <= '0;
      prdata <= RESET_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      pend_lo_q <= pend_lo_d;
      pend_hi_q <= pend_hi_d;
      en_lo_q <= en_lo_d;
      en_hi_q <= en_hi_d;
      qen_q <= qen_d;
      for (int r = 0; r < REGIONS; r++)
      begin
        grant_lo_q[r] <= grant_lo_d[r];
        grant_hi_q[r] <= grant_hi_d[r];
        qgrant_q[r] <= qgrant_d[r];
      end
      status_q <= status_d;
      mask_q <= mask_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      irq <= irq_d;
    end
  end

  assign cmpl_irq = irq_pulse;
  assign qdma_enable = qen_q;
endmodule // cmpl_irq_ctrl
`default_nettype wire

/* src/cmpl_irq_pkg.sv */
package cmpl_irq_pkg;
  localparam int NUM_REGIONS = 4;
  localparam int QDMA_CHANNELS = 8;
  localparam int CODE_W = 6;
  localparam int ADDR_W = 12;
  // register offsets inside one region window
  localparam logic [4:0] OFS_PEND_LO = 5'h00;
  localparam logic [4:0] OFS_PEND_HI = 5'h04;
  localparam logic [4:0] OFS_CLR_LO = 5'h08;
  localparam logic [4:0] OFS_CLR_HI = 5'h0C;
  localparam logic [4:0] OFS_EN_LO = 5'h10;
  localparam logic [4:0] OFS_EN_HI = 5'h14;
  localparam logic [4:0] OFS_EVALUATE = 5'h18;
  localparam logic [4:0] OFS_QDMA_EN = 5'h1C;
  localparam logic [ADDR_W-1:0] WINDOW_SIZE = 12'h020;
  localparam logic [ADDR_W-1:0] GLOBAL_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] SHADOW_BASE = 12'h200;
  localparam logic [ADDR_W-1:0] SHADOW_STRIDE = 12'h040;
  // region access enables, one block per region
  localparam logic [ADDR_W-1:0] ACC_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] ACC_STRIDE = 12'h010;
  localparam logic [3:0] ACC_DMA_LO = 4'h0;
  localparam logic [3:0] ACC_DMA_HI = 4'h4;
  localparam logic [3:0] ACC_QDMA = 4'h8;
  // interrupt status and mask
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 12'h180;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 12'h184;
  localparam int EVALUATE_TRIGGER_BIT = 0;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

/* src/region_irq_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module region_irq_gen
(
  input wire logic pclk, // controller clock
  input wire logic presetn, // async reset, active low
  input wire logic enabled_pending, // some enabled pending bit in this region
  input wire logic all_clear, // both pending registers are zero
  input wire logic evaluate_req, // evaluate write with trigger bit set
  output logic irq_q // one-cycle completion pulse
);
  logic armed_q;
  logic armed_d;
  logic irq_d;

  always_comb
  begin
    irq_d = enabled_pending && (armed_q || evaluate_req);
    armed_d = armed_q;
    if (irq_d)
      armed_d = 1'b0;
    else if (all_clear)
      armed_d = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      armed_q <= 1'b1;
      irq_q <= 1'b0;
    end
    else
    begin
      armed_q <= armed_d;
      irq_q <= irq_d;
    end
  end
endmodule // region_irq_gen
`default_nettype wire

/* tb/cmpl_irq_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module cmpl_irq_ctrl_asserts
  import cmpl_irq_pkg::*;
#(
  parameter int REGIONS = NUM_REGIONS
)
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [ADDR_W-1:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic code_valid, // code strobe
  input wire logic [CODE_W-1:0] completion_code, // code
  input wire logic [REGIONS:0] cmpl_irq, // pulses
  input wire logic [QDMA_CHANNELS-1:0] qdma_enable, // qdma bits
  input wire logic irq // level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  AST_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_SEL: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  AST_WR0: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on write");
  AST_PULSE: assert property (cmpl_irq != 0 |=> cmpl_irq == 0)
    else $error("completion pulse too long");
  AST_CAUSE: assert property (cmpl_irq != 0 |-> $past(code_valid, 2) || $past(code_valid, 3)
    || $past(pready) || $past(pready, 2)) else $error("pulse without code or evaluate");
  AST_IRQ: assert property ($rose(irq) |-> $past(cmpl_irq) != 0 || $past(pready) || $past(pready, 2))
    else $error("irq rose without cause");
  AST_QDMA: assert property (!$stable(qdma_enable) |-> $past(pready) && $past(pwrite) && !$past(pslverr))
    else $error("qdma bits changed without write");
endmodule // cmpl_irq_ctrl_asserts
`default_nettype wire

/* tb/irq_host.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_host
  import cmpl_irq_pkg::*;
#(
  parameter int REGIONS = NUM_REGIONS
)
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic [REGIONS:0] cmpl_irq, // pulses in
  output var logic [7:0] seen [0:REGIONS] // pulses counted per line
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    for (int r = 0; r <= REGIONS; r++)
      if (!presetn) seen[r] <= 8'h00;
      else if (cmpl_irq[r]) seen[r] <= seen[r] + 8'h01;
  end
endmodule // irq_host
`default_nettype wire

/* tb/dma_completion_irq_clear_evaluate_trigger_bit_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dma_completion_irq_clear_evaluate_trigger_bit_test;
  import cmpl_irq_pkg::*;
  localparam int REGIONS = NUM_REGIONS;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, code_valid = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd_q, w;
  logic pready, pslverr, irq, err_q;
  logic [CODE_W-1:0] completion_code = '0;
  logic [REGIONS:0] cmpl_irq;
  logic [QDMA_CHANNELS-1:0] qdma_enable;
  logic [7:0] seen [0:REGIONS];
  logic [63:0] pend = '0;
  int exp_cnt [0:REGIONS] = '{default: 0};
  int failures = 0, total_checks = 0, lfsr = 54788;
  cmpl_irq_ctrl #(.REGIONS(REGIONS)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .code_valid(code_valid), .completion_code(completion_code), .cmpl_irq(cmpl_irq),
    .qdma_enable(qdma_enable), .irq(irq));
  irq_host #(.REGIONS(REGIONS)) host (.pclk(pclk), .presetn(presetn), .cmpl_irq(cmpl_irq), .seen(seen));
  initial forever #50 pclk = ~pclk;
  function automatic int lfsr_next(input int v);
    return {16'h0, v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask
  task automatic send(input int n);
    @(posedge pclk);
    code_valid <= 1'b1;
    completion_code <= n[CODE_W-1:0];
    @(posedge pclk);
    code_valid <= 1'b0;
    pend[n] = 1'b1;
  endtask
  task automatic pulses;
    repeat (4) @(posedge pclk);
    for (int r = 0; r <= REGIONS; r++) chk({24'h0, seen[r]}, exp_cnt[r]);
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #(3000 * 100);
    failures++;
    test_done();
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      lfsr = lfsr_next(lfsr);
      w = {lfsr[15:0], ~lfsr[15:0]};
      wr(12'h010, w);
      rd(12'h010, w);
    end
    wr(12'h010, 32'h8);
    wr(12'h014, 32'h100);
    wr(12'h100, 32'hFFFF_FFFF);
    wr(12'h104, 32'hFFFF_FFFF);
    send(3);
    exp_cnt[0]++;
    exp_cnt[REGIONS]++;
    pulses();
    rd(12'h000, pend[31:0]);
    send(40);
    pulses();
    rd(12'h004, pend[63:32]);
    wr(12'h008, 32'hFFFF_FFF7);
    rd(12'h000, pend[31:0]);
    wr(12'h008, 32'h8);
    pend[3] = 1'b0;
    rd(12'h000, pend[31:0]);
    rd(12'h004, pend[63:32]);
    wr(12'h00C, 32'h100);
    pend[40] = 1'b0;
    rd(12'h004, pend[63:32]);
    send(3);
    exp_cnt[0]++;
    exp_cnt[REGIONS]++;
    pulses();
    wr(12'h218, 32'h1);
    exp_cnt[0]++;
    pulses();
    wr(12'h218, 32'h0);
    pulses();
    wr(12'h110, 32'h8);
    exp_cnt[1]++;
    pulses();
    wr(12'h258, 32'h1);
    exp_cnt[1]++;
    pulses();
    wr(12'h018, 32'h1);
    exp_cnt[REGIONS]++;
    pulses();
    chk(irq, 1'b0);
    wr(12'h184, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    wr(12'h180, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    wr(12'h01C, 32'h5A);
    @(negedge pclk);
    chk(qdma_enable, 8'h5A);
    wr(12'h29C, 32'h0F);
    @(negedge pclk);
    chk(qdma_enable, 8'h5A);
    wr(12'h128, 32'hFF);
    wr(12'h29C, 32'h0F);
    @(negedge pclk);
    chk(qdma_enable, 8'h0F);
    apb(1'b0, 12'hFFC, 32'h0);
    chk(err_q, 1'b1);
    // code 3 lands on the very edge that clears bit 3
    pend[3] = 1'b0;
    fork
      wr(12'h008, 32'h8);
      begin
        repeat (2) @(posedge pclk);
        send(3);
      end
    join
    rd(12'h000, pend[31:0]);
    test_done();
  end
endmodule // dma_completion_irq_clear_evaluate_trigger_bit_test
bind cmpl_irq_ctrl cmpl_irq_ctrl_asserts #(.REGIONS(REGIONS)) chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .code_valid(code_valid), .completion_code(completion_code),
  .cmpl_irq(cmpl_irq), .qdma_enable(qdma_enable), .irq(irq));
`default_nettype wire
